//--- smc_top.v
// Supply monitor control, reference control and supply channel routing
`timescale 1ns/100ps
`include "smc_map.vh"
module smc_top #(
  parameter ADDR_W         = `SMC_ADDR_W,
  parameter DATA_W         = `SMC_DATA_W,
  parameter CHAN_W         = `SMC_CHAN_W,
  parameter SETTLE_CYCLES  = `SMC_SETTLE_CYCLES,
  parameter EPISODE_W      = 8
) (
  input  wire                clk,
  input  wire                rst,
  input  wire [ADDR_W-1:0]   reg_addr,
  input  wire [DATA_W-1:0]   reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [DATA_W-1:0]   reg_rdata,
  input  wire                supply_above_trip,
  input  wire                normal_irq_enable_reg,
  input  wire                fast_irq_enable_reg,
  output wire                normal_irq_req,
  output wire                fast_irq_req,
  output reg                 monitor_enable,
  output reg                 trip_level_select,
  output reg                 ref_1v2_out_en,
  output reg                 ref_2v5_out_en,
  output reg                 ref_buf_out_en,
  output reg  [CHAN_W-1:0]   adc_positive_channel_select,
  output reg                 adc_route_io_supply
);

  // Settle counts above 65536 would need a wider counter
  localparam                CNT_W         = 16;
  localparam [31:0]         SETTLE_LAST_W = SETTLE_CYCLES - 1;
  localparam [CNT_W-1:0]    SETTLE_LAST   = SETTLE_LAST_W[CNT_W-1:0];
  localparam [DATA_W-1:0]   MON_RST       = `SMC_MON_CTRL_RESET;
  localparam [DATA_W-1:0]   REF_RST       = `SMC_REF_CTRL_RESET;
  localparam [0:0]          REF_BUF_RST   = (REF_RST != `SMC_ZERO_BYTE);
  // Comparator history reads high at reset, as an idle monitor would
  localparam [0:0]          CMP_RST       = 1'b1;

  // Decode of one register address, shared by read and write paths
  function hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // Channel code that selects the monitored supply
  function is_supply_chan;
    input [CHAN_W-1:0] code;
    begin
      is_supply_chan = (code == `SMC_CHAN_IO_SUPPLY);
    end
  endfunction

  wire                 cmp_sync;
  reg                  cmp_prev_q;
  reg                  flag_q;
  reg                  flag_d;
  reg                  served_q;
  reg                  served_d;
  reg  [DATA_W-1:0]    ref_ctrl_q;
  reg  [DATA_W-1:0]    ref_ctrl_d;
  reg  [CHAN_W-1:0]    chan_d;
  reg  [CNT_W-1:0]     settle_cnt_q;
  reg  [CNT_W-1:0]     settle_cnt_d;
  reg                  settled_q;
  reg                  settled_d;
  reg  [EPISODE_W-1:0] episodes_q;
  reg  [EPISODE_W-1:0] episodes_d;
  reg  [DATA_W-1:0]    rdata_d;
  reg                  mon_en_d;
  reg                  trip_d;

  wire wr_mon;
  wire wr_ref;
  wire wr_chan;
  wire wr_epi;
  wire clear_req;
  wire low_entry;

  // Comparator is asynchronous; reset value 1 makes bit 3 read high at first
  smc_sync2 #(
    .RESET_VAL (CMP_RST)
  ) u_cmp_sync (
    .clk       (clk),
    .rst       (rst),
    .async_in  (supply_above_trip),
    .sync_out  (cmp_sync)
  );

  smc_irq_gate u_irq (
    .clk                   (clk),
    .rst                   (rst),
    .flag                  (flag_q),
    .served                (served_q),
    .normal_irq_enable_reg (normal_irq_enable_reg),
    .fast_irq_enable_reg   (fast_irq_enable_reg),
    .normal_irq_req        (normal_irq_req),
    .fast_irq_req          (fast_irq_req)
  );

  assign wr_mon    = reg_wr & hit(reg_addr, `SMC_ADDR_MON_CTRL);
  assign wr_ref    = reg_wr & hit(reg_addr, `SMC_ADDR_REF_CTRL);
  assign wr_chan   = reg_wr & hit(reg_addr, `SMC_ADDR_ADC_CHAN);
  assign wr_epi    = reg_wr & hit(reg_addr, `SMC_ADDR_EPISODES);
  assign clear_req = wr_mon & reg_wdata[`SMC_MON_FLAG_BIT];
  assign low_entry = cmp_prev_q & ~cmp_sync;

  // Low-supply flag and its served marker
  always @* begin
    flag_d   = flag_q;
    served_d = served_q;
    if (!cmp_sync) begin
      // Low level wins over any clearing write
      flag_d = 1'b1;
      if (clear_req) begin
        // Write of 1 while low only marks the episode as handled
        served_d = flag_q;
      end
    end else begin
      served_d = 1'b0;
      if (clear_req) begin
        flag_d = 1'b0;
      end
    end
  end

  // Monitor control stored bits; reserved bits are not kept
  always @* begin
    mon_en_d = monitor_enable;
    trip_d   = trip_level_select;
    if (wr_mon) begin
      mon_en_d = reg_wdata[`SMC_MON_ENABLE_BIT];
      trip_d   = reg_wdata[`SMC_MON_TRIP_BIT];
    end
  end

  // Reference control, all eight bits kept
  always @* begin
    ref_ctrl_d = ref_ctrl_q;
    if (wr_ref) begin
      ref_ctrl_d = reg_wdata;
    end
  end

  // Channel select and settling timer; restarts on every channel write
  always @* begin
    chan_d       = adc_positive_channel_select;
    settle_cnt_d = settle_cnt_q;
    settled_d    = settled_q;
    if (wr_chan) begin
      chan_d       = reg_wdata[CHAN_W-1:0];
      settle_cnt_d = {CNT_W{1'b0}};
      settled_d    = 1'b0;
    end else if (!settled_q) begin
      if (settle_cnt_q == SETTLE_LAST) begin
        settled_d = 1'b1;
      end else begin
        settle_cnt_d = settle_cnt_q + 1'b1;
      end
    end
  end

  // Count of low-supply episodes, saturating, cleared by any write
  always @* begin
    episodes_d = episodes_q;
    if (wr_epi) begin
      // A drop in the clearing cycle is still counted
      episodes_d = {{(EPISODE_W-1){1'b0}}, low_entry};
    end else if (low_entry && (episodes_q != {EPISODE_W{1'b1}})) begin
      episodes_d = episodes_q + 1'b1;
    end
  end

  // Read mux; unmapped addresses return zero
  always @* begin
    rdata_d = `SMC_ZERO_BYTE;
    if (hit(reg_addr, `SMC_ADDR_MON_CTRL)) begin
      rdata_d[`SMC_MON_FLAG_BIT]   = flag_q;
      rdata_d[`SMC_MON_ENABLE_BIT] = monitor_enable;
      rdata_d[`SMC_MON_TRIP_BIT]   = trip_level_select;
      rdata_d[`SMC_MON_CMP_BIT]    = cmp_sync;
    end else if (hit(reg_addr, `SMC_ADDR_REF_CTRL)) begin
      rdata_d = ref_ctrl_q;
    end else if (hit(reg_addr, `SMC_ADDR_ADC_CHAN)) begin
      rdata_d[CHAN_W-1:0]            = adc_positive_channel_select;
      rdata_d[`SMC_CHAN_SETTLED_BIT] = settled_q;
    end else if (hit(reg_addr, `SMC_ADDR_EPISODES)) begin
      rdata_d = episodes_q;
    end
  end

  // Low-supply flag; bit 0 is clear in the monitor control reset value
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= MON_RST[`SMC_MON_FLAG_BIT];
    end else begin
      flag_q <= flag_d;
    end
  end

  // Served marker
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      served_q <= 1'b0;
    end else begin
      served_q <= served_d;
    end
  end

  // History starts at the synchroniser's reset level: no false drop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_prev_q <= CMP_RST;
    end else begin
      cmp_prev_q <= cmp_sync;
    end
  end

  // Reference control store
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_ctrl_q <= REF_RST;
    end else begin
      ref_ctrl_q <= ref_ctrl_d;
    end
  end

  // Settle counter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_cnt_q <= {CNT_W{1'b0}};
    end else begin
      settle_cnt_q <= settle_cnt_d;
    end
  end

  // Idle channel counts as settled after reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      settled_q <= 1'b1;
    end else begin
      settled_q <= settled_d;
    end
  end

  // Episode counter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      episodes_q <= {EPISODE_W{1'b0}};
    end else begin
      episodes_q <= episodes_d;
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `SMC_ZERO_BYTE;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : `SMC_ZERO_BYTE;
    end
  end

  // Monitor power pin
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      monitor_enable <= MON_RST[`SMC_MON_ENABLE_BIT];
    end else begin
      monitor_enable <= mon_en_d;
    end
  end

  // Trip level pin
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trip_level_select <= MON_RST[`SMC_MON_TRIP_BIT];
    end else begin
      trip_level_select <= trip_d;
    end
  end

  // Low reference output switch
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_1v2_out_en <= REF_RST[`SMC_REF_1V2_BIT];
    end else begin
      ref_1v2_out_en <= ref_ctrl_d[`SMC_REF_1V2_BIT];
    end
  end

  // High reference output switch
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_2v5_out_en <= REF_RST[`SMC_REF_2V5_BIT];
    end else begin
      ref_2v5_out_en <= ref_ctrl_d[`SMC_REF_2V5_BIT];
    end
  end

  // Buffers stay on unless the whole register is cleared
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_buf_out_en <= REF_BUF_RST;
    end else begin
      ref_buf_out_en <= (ref_ctrl_d != `SMC_ZERO_BYTE);
    end
  end

  // Channel code pins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_positive_channel_select <= `SMC_ADC_CHAN_RESET;
    end else begin
      adc_positive_channel_select <= chan_d;
    end
  end

  // Route decoded from the same next code, so pins never disagree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_route_io_supply <= 1'b0;
    end else begin
      adc_route_io_supply <= is_supply_chan(chan_d);
    end
  end

endmodule

//--- smc_map.vh
// Register map, field positions and timing constants of the supply monitor block
`ifndef SMC_MAP_VH
`define SMC_MAP_VH

`define SMC_ADDR_W            32
`define SMC_DATA_W            8

`define SMC_ADDR_MON_CTRL     32'hffff0440
`define SMC_ADDR_REF_CTRL     32'hffff0480
`define SMC_ADDR_ADC_CHAN     32'hffff0500
`define SMC_ADDR_EPISODES     32'hffff0504

`define SMC_MON_FLAG_BIT      0
`define SMC_MON_ENABLE_BIT    1
`define SMC_MON_TRIP_BIT      2
`define SMC_MON_CMP_BIT       3

`define SMC_REF_1V2_BIT       0
`define SMC_REF_2V5_BIT       1
`define SMC_REF_BUF_BIT       2

`define SMC_CHAN_W            5
`define SMC_CHAN_IO_SUPPLY    5'h13
`define SMC_CHAN_SETTLED_BIT  7

`define SMC_MON_CTRL_RESET    8'h00
`define SMC_REF_CTRL_RESET    8'h01
`define SMC_ADC_CHAN_RESET    5'h00
`define SMC_ZERO_BYTE         8'h00

`define SMC_CLK_MHZ           25
`define SMC_SETTLE_NS         60000
`define SMC_SETTLE_CYCLES     ((`SMC_SETTLE_NS * `SMC_CLK_MHZ + 999) / 1000)

`endif

//--- smc_sync2.v
// Two-flop synchroniser for the asynchronous comparator level
`timescale 1ns/100ps
module smc_sync2 #(
  parameter RESET_VAL = 1'b1
) (
  input  wire clk,
  input  wire rst,
  input  wire async_in,
  output reg  sync_out
);
  reg meta_q;

  // First stage feeds only the second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

//--- smc_irq_gate.v
// Interrupt request gating towards the normal and fast interrupt lines
`timescale 1ns/100ps
module smc_irq_gate (
  input  wire clk,
  input  wire rst,
  input  wire flag,
  input  wire served,
  input  wire normal_irq_enable_reg,
  input  wire fast_irq_enable_reg,
  output reg  normal_irq_req,
  output reg  fast_irq_req
);
  wire pending;

  // Served episodes stay quiet until the supply recovers
  assign pending = flag & ~served;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      normal_irq_req <= 1'b0;
      fast_irq_req   <= 1'b0;
    end else begin
      normal_irq_req <= pending & normal_irq_enable_reg;
      fast_irq_req   <= pending & fast_irq_enable_reg;
    end
  end
endmodule

//--- smc_props.sv
// Assertion checker for the supply monitor block
`timescale 1ns/100ps
`include "smc_map.vh"
module smc_props (
  input wire        clk,
  input wire        rst,
  input wire [31:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        supply_above_trip,
  input wire        normal_irq_enable_reg,
  input wire        fast_irq_enable_reg,
  input wire        normal_irq_req,
  input wire        fast_irq_req,
  input wire [4:0]  adc_positive_channel_select,
  input wire        adc_route_io_supply
);
  wire hit = reg_addr == `SMC_ADDR_MON_CTRL;
  wire clr = reg_wr && hit && reg_wdata[0];
  wire irq = normal_irq_req || fast_irq_req;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Three equal samples: the synchroniser has caught up
  sequence s_hi; supply_above_trip[*3]; endsequence
  sequence s_lo; !supply_above_trip[*3]; endsequence
  sequence s_drop;
    s_hi ##1 (!supply_above_trip && normal_irq_enable_reg && !reg_wr)[*5];
  endsequence
  a_route_code: assert property (
    adc_route_io_supply == (adc_positive_channel_select == `SMC_CHAN_IO_SUPPLY))
    else $error("route wrong");
  a_cmp_high: assert property (s_hi ##0 (reg_rd && hit) |=> reg_rdata[7:3] == 5'h01)
    else $error("status bit not high");
  a_cmp_low: assert property (s_lo ##0 (reg_rd && hit) |=> !reg_rdata[3])
    else $error("status bit not low");
  a_norm_gate: assert property (normal_irq_req |-> $past(normal_irq_enable_reg))
    else $error("normal request while disabled");
  a_fast_gate: assert property (fast_irq_req |-> $past(fast_irq_enable_reg))
    else $error("fast request while disabled");
  a_low_raises: assert property (s_drop |=> normal_irq_req)
    else $error("no request after drop");
  a_served_quiet: assert property (!supply_above_trip[*6] ##0 clr ##1 s_lo |=> !irq)
    else $error("request repeated while low");
  a_clear_high: assert property (s_hi ##0 clr |=> ##1 !irq)
    else $error("clear while high not taken");
endmodule
bind smc_top smc_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .supply_above_trip(supply_above_trip), .normal_irq_req(normal_irq_req),
  .normal_irq_enable_reg(normal_irq_enable_reg), .fast_irq_req(fast_irq_req),
  .fast_irq_enable_reg(fast_irq_enable_reg), .adc_route_io_supply(adc_route_io_supply),
  .adc_positive_channel_select(adc_positive_channel_select));

//--- smc_core_model.sv
// Interrupt controller model: source enables for the monitor
`timescale 1ns/100ps
module smc_core_model (
  input  wire       clk,
  input  wire       rst,
  input  wire [1:0] irq_sel,
  output reg        normal_irq_enable_reg,
  output reg        fast_irq_enable_reg
);
  // Enables move only on the clock, as a real enable bank would
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      normal_irq_enable_reg <= 1'b0;
      fast_irq_enable_reg   <= 1'b0;
    end else begin
      normal_irq_enable_reg <= irq_sel[0];
      fast_irq_enable_reg   <= irq_sel[1];
    end
  end
endmodule

//--- test_supply_monitor_and_ref_control.sv
// Self-checking bench for the supply monitor block
`timescale 1ns/100ps
`include "smc_map.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module test_supply_monitor_and_ref_control;
  localparam [31:0] MON = `SMC_ADDR_MON_CTRL;
  localparam [31:0] REF = `SMC_ADDR_REF_CTRL;
  localparam [31:0] CHN = `SMC_ADDR_ADC_CHAN;
  localparam [31:0] EPI = `SMC_ADDR_EPISODES;
  reg        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sup = 1'b1;
  reg [31:0] adr = 32'h0;
  reg [7:0]  wd = 8'h00, d;
  reg [1:0]  sel = 2'h0;
  wire [7:0] rdat;
  wire [4:0] ch;
  wire       ne, fe, nq, fq, men, tp, r1, r2, rb, rt;
  int        error_cnt = 0, cmp_count = 0;
  smc_top #(.SETTLE_CYCLES(4)) u_dut (.clk(clk), .rst(rst), .reg_addr(adr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .supply_above_trip(sup),
    .normal_irq_enable_reg(ne), .fast_irq_enable_reg(fe), .normal_irq_req(nq),
    .fast_irq_req(fq), .monitor_enable(men), .trip_level_select(tp), .ref_1v2_out_en(r1),
    .ref_2v5_out_en(r2), .ref_buf_out_en(rb), .adc_positive_channel_select(ch),
    .adc_route_io_supply(rt));
  smc_core_model u_core (.clk(clk), .rst(rst), .irq_sel(sel),
    .normal_irq_enable_reg(ne), .fast_irq_enable_reg(fe));
  task test_done;
    $display("Counts: %0d errors in %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task w(input [31:0] a, input [7:0] v);
    @(posedge clk) {wr, adr, wd} <= {1'b1, a, v};
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask
  task r(input [31:0] a);
    @(posedge clk) {rd, adr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    #1 d = rdat;
  endtask
  // Bounded wait; a missing request ends the run
  task wait_irq(input bit f);
    int i;
    for (i = 0; i < 20 && (f ? fq : nq) !== 1'b1; i++) @(posedge clk);
    `CHK("irq wait", 1'b1, f ? fq : nq)
    if ((f ? fq : nq) !== 1'b1) test_done;
  endtask
  task t_reset;
    r(MON);
    `CHK("ctrl reset", 8'h08, d)
    r(REF);
    `CHK("ref reset", 8'h01, d)
    `CHK("ref pins", 3'b101, {rb, r2, r1})
    r(32'hffff0444);
    `CHK("unmapped", 8'h00, d)
  endtask
  task ref_step(input [7:0] v);
    w(REF, v);
    `CHK("ref pins", {v != 8'h00, v[1:0]}, {rb, r2, r1})
    r(REF);
    `CHK("ref read", v, d)
  endtask
  // Buffer pin rb kept at 1 unless the whole register is cleared
  task t_ref;
    ref_step(8'h07);
    ref_step(8'h06);
    ref_step(8'h00);
    ref_step(8'h05);
  endtask
  task t_mon;
    w(MON, 8'h06);
    `CHK("mon pins", 2'b11, {tp, men})
    r(MON);
    `CHK("ctrl rw", 8'h0e, d)
    w(MON, 8'h02);
    `CHK("mon pins", 2'b01, {tp, men})
  endtask
  task t_chan;
    // Input buffer lives outside this block
    w(CHN, 8'h13);
    `CHK("route on", 1'b1, rt)
    `CHK("chan", 5'h13, ch)
    r(CHN);
    `CHK("settling", 8'h13, d)
    r(CHN);
    `CHK("still settling", 8'h13, d)
    r(CHN);
    `CHK("settled", 8'h93, d)
    w(CHN, 8'h12);
    `CHK("route off", 1'b0, rt)
  endtask
  task t_low;
    @(posedge clk) sel <= 2'b01;
    cyc(2);
    @(posedge clk) sup <= 1'b0;
    wait_irq(1'b0);
    r(MON);
    `CHK("ctrl low", 8'h03, d)
    w(MON, 8'h0b);
    cyc(8);
    `CHK("irq held off", 1'b0, nq)
    r(MON);
    `CHK("flag kept", 8'h03, d)
    @(posedge clk) sup <= 1'b1;
    cyc(3);
    w(MON, 8'h02);
    r(MON);
    `CHK("zero write", 8'h0b, d)
    w(MON, 8'h03);
    r(MON);
    `CHK("flag clear", 8'h0a, d)
    `CHK("irq idle", 1'b0, nq)
  endtask
  task t_fast;
    @(posedge clk) sel <= 2'b10;
    cyc(2);
    @(posedge clk) sup <= 1'b0;
    wait_irq(1'b1);
    `CHK("normal idle", 1'b0, nq)
    @(posedge clk) sel <= 2'b00;
    cyc(3);
    `CHK("fast masked", 1'b0, fq)
    @(posedge clk) sup <= 1'b1;
    cyc(3);
    w(MON, 8'h03);
    r(MON);
    `CHK("flag clear", 8'h0a, d)
    r(EPI);
    `CHK("episodes", 8'h02, d)
    w(EPI, 8'h00);
    r(EPI);
    `CHK("episodes clear", 8'h00, d)
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    cyc(2);
    rst <= 1'b0;
    t_reset;
    t_ref;
    t_mon;
    t_chan;
    t_low;
    t_fast;
    test_done;
  end
endmodule
